// ---- logic/lsbc_top.sv ----
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "lsbc_cfg.svh"
module lsbc_top #(
    parameter int unsigned IDLE_CYC = `LSBC_IDLE_CYC
) (
    // Clock and reset.
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    // Wishbone slave.
    input  wire logic [31:0] WB_ADR_I,
    input  wire logic [31:0] WB_DAT_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic        WB_WE_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // System prescale setting.
    input  wire logic [1:0]  LIN_PRESCALE,
    // Transceiver lines and interrupt.
    input  wire logic        LIN_RXD,
    output logic             LIN_TXD,
    output logic             LIN_IRQ
);
    // ==========================================================
    // Register bus
    logic                ack_q;
    logic [31:0]         dat_q;
    logic [31:0]         rdata;
    logic                req, wr, rd;
    lsbc_pkg::lsbc_ctrl_s ctrl_q;
    lsbc_pkg::lsbc_flags_t flags_q, flags_d, fset, fclr, mask_q;
    logic [7:0]          div_lo_q;
    logic [6:0]          div_hi_q;
    logic [14:0]         div;
    logic [7:0]          rxbuf_q, txbuf_q;
    logic                abort, wr_data, rd_data, rd_flags;
    logic                rx_synced_q, rx_busy_q;
    lsbc_pkg::lsbc_rx_e  rx_st_q;
    lsbc_pkg::lsbc_tx_e  tx_st_q;
    logic                tx_busy;

    assign req      = WB_CYC_I & WB_STB_I & ~ack_q;
    assign wr       = req & WB_WE_I & WB_SEL_I[0];
    assign rd       = req & ~WB_WE_I;
    assign abort    = wr & (WB_ADR_I == `LSBC_A_CTRL) & WB_DAT_I[`LSBC_C_ABORT];
    assign wr_data  = wr & (WB_ADR_I == `LSBC_A_DATA);
    assign rd_data  = rd & (WB_ADR_I == `LSBC_A_DATA);
    assign rd_flags = rd & (WB_ADR_I == `LSBC_A_FLAGS);
    assign div      = {div_hi_q, div_lo_q};
    assign tx_busy  = (tx_st_q == lsbc_pkg::TX_SHIFT);

    always_comb begin
        unique case (WB_ADR_I)
            `LSBC_A_CTRL:  rdata = 32'({tx_busy, rx_busy_q, rx_synced_q, ctrl_q, 1'b0});
            `LSBC_A_FLAGS: rdata = 32'(flags_q);
            `LSBC_A_DATA:  rdata = 32'(rxbuf_q);
            `LSBC_A_MASK:  rdata = 32'(mask_q);
            `LSBC_A_DIVLO: rdata = 32'(div_lo_q);
            `LSBC_A_DIVHI: rdata = 32'(div_hi_q);
            default:       rdata = 32'h0;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= req;
            dat_q <= rd ? rdata : 32'h0;
        end
    end
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= '0;
            mask_q <= 8'h00;
        end else if (wr) begin
            if (WB_ADR_I == `LSBC_A_CTRL) begin
                ctrl_q <= {WB_DAT_I[`LSBC_C_IDLE], WB_DAT_I[`LSBC_C_FAST],
                           WB_DAT_I[`LSBC_C_OFF]};
            end
            if (WB_ADR_I == `LSBC_A_MASK) begin
                mask_q <= WB_DAT_I[7:0];
            end
        end
    end

    assign LIN_IRQ = |(flags_q & mask_q);

    // ==========================================================
    // Prescale tick, input synchroniser and filter
    logic [3:0] pre_q, pre_mask;
    logic       tick;
    logic [1:0] rxs_q;
    logic [1:0] filt_q;
    logic       rxf_q, rxp_q, fall, rise;

    assign pre_mask = (4'h2 << LIN_PRESCALE) - 4'h1;
    assign tick     = ((pre_q & pre_mask) == pre_mask);
    assign fall     = rxp_q & ~rxf_q;
    assign rise     = ~rxp_q & rxf_q;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre_q <= 4'h0;
            rxs_q <= 2'b11;
        end else begin
            pre_q <= tick ? 4'h0 : pre_q + 4'h1;
            rxs_q <= {rxs_q[0], LIN_RXD};
        end
    end

    // Filtered line follows the pin only after it held for several ticks.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            filt_q <= 2'd0;
            rxf_q  <= 1'b1;
            rxp_q  <= 1'b1;
        end else begin
            rxp_q <= rxf_q;
            if (ctrl_q.path_off) begin
                filt_q <= 2'd0;
                rxf_q  <= 1'b1;
                rxp_q  <= 1'b1;
            end else if (tick) begin
                if (rxs_q[1] == rxf_q) begin
                    filt_q <= 2'd0;
                end else if (filt_q == `LSBC_FILT) begin
                    filt_q <= 2'd0;
                    rxf_q  <= rxs_q[1];
                end else begin
                    filt_q <= filt_q + 2'd1;
                end
            end
        end
    end

    // ==========================================================
    // Break and sync detection, receiver
    logic [19:0] brk_q, len_q, t8_q;
    logic [2:0]  edges_q;
    logic [3:0]  rbit_q;
    logic [14:0] rcnt_q;
    logic [7:0]  rsh_q;
    logic [16:0] bitlen, bmin, bmax;
    logic [23:0] brk_x8, t8_x11;
    logic        det_ok, det, byte_done, tx_start;

    assign bitlen = t8_q[19:`LSBC_SYNC_SH];
    assign bmin   = !ctrl_q.fast ? 17'(`LSBC_BIT_SLOW0 >> LIN_PRESCALE) :
                    (LIN_PRESCALE == `LSBC_PRESC_F3) ? 17'(`LSBC_BIT_F30 >> LIN_PRESCALE) :
                    17'(`LSBC_BIT_FAST0 >> LIN_PRESCALE);
    assign bmax   = 17'(`LSBC_BIT_MAX0 >> LIN_PRESCALE);
    assign brk_x8 = {1'b0, len_q, 3'b000};
    assign t8_x11 = 24'(t8_q) * 24'(`LSBC_BRK_BITS);
    assign det_ok = (brk_x8 >= t8_x11) & (bitlen >= bmin) & (bitlen <= bmax)
                  & (bitlen <= 17'(`LSBC_BIT_TOP));
    assign det    = (rx_st_q == lsbc_pkg::RX_SYNC) & fall
                  & (edges_q == `LSBC_SYNC_LAST) & det_ok
                  & ~ctrl_q.path_off & ~abort;
    assign byte_done = (rx_st_q == lsbc_pkg::RX_DATA) & tick & (rcnt_q == 15'h0)
                     & (rbit_q == `LSBC_LAST_BIT) & rxf_q;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            brk_q <= 20'h0;
        end else if (fall) begin
            brk_q <= 20'h0;
        end else if (tick & ~rxf_q & ~&brk_q) begin
            brk_q <= brk_q + 20'h1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_st_q     <= lsbc_pkg::RX_HUNT;
            rx_synced_q <= 1'b0;
            rx_busy_q   <= 1'b0;
            len_q       <= 20'h0;
            t8_q        <= 20'h0;
            edges_q     <= 3'd0;
            rbit_q      <= 4'd0;
            rcnt_q      <= 15'h0;
            rsh_q       <= 8'h00;
        end else if (ctrl_q.path_off | abort | tx_start) begin
            rx_st_q     <= lsbc_pkg::RX_HUNT;
            rx_synced_q <= 1'b0;
            rx_busy_q   <= 1'b0;
        end else begin
            unique case (rx_st_q)
                lsbc_pkg::RX_HUNT: begin
                    if (fall) begin
                        rx_st_q <= lsbc_pkg::RX_BREAK;
                    end
                end
                lsbc_pkg::RX_BREAK: begin
                    if (rise) begin
                        rx_st_q <= lsbc_pkg::RX_SYNC;
                        len_q   <= brk_q;
                        t8_q    <= 20'h0;
                        edges_q <= 3'd0;
                    end
                end
                lsbc_pkg::RX_SYNC: begin
                    if (fall) begin
                        edges_q <= edges_q + 3'd1;
                        if (edges_q == 3'd0) begin
                            t8_q <= 20'h0;
                        end
                        if (edges_q == `LSBC_SYNC_LAST) begin
                            rx_st_q <= det ? lsbc_pkg::RX_IDLE : lsbc_pkg::RX_BREAK;
                            if (det) begin
                                rx_synced_q <= 1'b1;
                                rx_busy_q   <= 1'b0;
                            end
                        end
                    end else if (tick) begin
                        if (&t8_q) begin
                            rx_st_q <= lsbc_pkg::RX_HUNT;
                        end else begin
                            t8_q <= t8_q + 20'h1;
                        end
                    end
                end
                lsbc_pkg::RX_IDLE: begin
                    if (fall) begin
                        rx_st_q   <= lsbc_pkg::RX_DATA;
                        rx_busy_q <= 1'b1;
                        rbit_q    <= 4'd0;
                        rcnt_q    <= div >> 1;
                    end
                end
                lsbc_pkg::RX_DATA: begin
                    if (tick) begin
                        if (rcnt_q != 15'h0) begin
                            rcnt_q <= rcnt_q - 15'h1;
                        end else begin
                            rcnt_q <= div;
                            rbit_q <= rbit_q + 4'd1;
                            if (rbit_q == `LSBC_LAST_BIT) begin
                                rx_busy_q <= 1'b0;
                                rx_st_q <= rxf_q ? lsbc_pkg::RX_IDLE : lsbc_pkg::RX_BREAK;
                            end else if (rbit_q == 4'd0) begin
                                if (rxf_q) begin
                                    rx_busy_q <= 1'b0;
                                    rx_st_q   <= lsbc_pkg::RX_IDLE;
                                end
                            end else begin
                                rsh_q <= {rxf_q, rsh_q[7:1]};
                            end
                        end
                    end
                end
                default: rx_st_q <= lsbc_pkg::RX_HUNT;
            endcase
        end
    end

    // Detector owns the divisor; software may program it for debug.
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_lo_q <= `LSBC_DIVLO_RST;
            div_hi_q <= `LSBC_DIVHI_RST;
        end else if (det) begin
            {div_hi_q, div_lo_q} <= 15'(bitlen - 17'h1);
        end else if (wr & (WB_ADR_I == `LSBC_A_DIVLO)) begin
            div_lo_q <= WB_DAT_I[7:0];
        end else if (wr & (WB_ADR_I == `LSBC_A_DIVHI)) begin
            div_hi_q <= WB_DAT_I[6:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rxbuf_q <= 8'h00;
        end else if (byte_done & ~flags_q[`LSBC_F_FULL]) begin
            rxbuf_q <= rsh_q;
        end
    end

    // ==========================================================
    // Transmitter
    logic [9:0]  tsh_q;
    logic [3:0]  tbit_q;
    logic [14:0] tcnt_q;
    logic        txd_q, mid, t_clash, t_force, t_end, t_reload;

    assign tx_start = (tx_st_q == lsbc_pkg::TX_IDLE) & ~flags_q[`LSBC_F_VAC];
    assign mid      = tx_busy & tick & (tcnt_q == (div >> 1));
    assign t_clash  = mid & txd_q & ~rxf_q;
    assign t_force  = mid & ~txd_q & rxf_q;
    assign t_end    = tx_busy & tick & (tcnt_q == 15'h0) & (tbit_q == `LSBC_LAST_BIT);
    assign t_reload = t_end & ~flags_q[`LSBC_F_VAC] & ~det;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_st_q <= lsbc_pkg::TX_IDLE;
            tsh_q   <= 10'h3ff;
            tbit_q  <= 4'd0;
            tcnt_q  <= 15'h0;
            txd_q   <= 1'b1;
        end else if (tx_start | t_reload) begin
            tx_st_q <= lsbc_pkg::TX_SHIFT;
            tsh_q   <= {1'b1, txbuf_q, 1'b0};
            tbit_q  <= 4'd0;
            tcnt_q  <= div;
            txd_q   <= 1'b0;
        end else if (tx_busy & (det | t_clash | t_force | t_end)) begin
            tx_st_q <= lsbc_pkg::TX_IDLE;
            txd_q   <= 1'b1;
        end else if (tx_busy & tick) begin
            if (tcnt_q != 15'h0) begin
                tcnt_q <= tcnt_q - 15'h1;
            end else begin
                tcnt_q <= div;
                tbit_q <= tbit_q + 4'd1;
                tsh_q  <= {1'b1, tsh_q[9:1]};
                txd_q  <= tsh_q[1];
            end
        end
    end
    assign LIN_TXD = txd_q;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            txbuf_q <= 8'h00;
        end else if (wr_data & flags_q[`LSBC_F_VAC]) begin
            txbuf_q <= WB_DAT_I[7:0];
        end
    end

    // ==========================================================
    // Idle timer and status flags
    logic [31:0] idle_q;
    logic        idle_hit;

    assign idle_hit = ctrl_q.idle_on & ~(fall | rise) & (idle_q == IDLE_CYC - 1);

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            idle_q <= 32'h0;
        end else if (~ctrl_q.idle_on | fall | rise) begin
            idle_q <= 32'h0;
        end else if (idle_q != IDLE_CYC) begin
            idle_q <= idle_q + 32'h1;
        end
    end

    always_comb begin
        fset = '0;
        fset[`LSBC_F_HDR]   = det;
        fset[`LSBC_F_FULL]  = byte_done & ~flags_q[`LSBC_F_FULL];
        fset[`LSBC_F_VAC]   = tx_start | t_reload;
        fset[`LSBC_F_CLASH] = t_clash;
        fset[`LSBC_F_OVR]   = byte_done & flags_q[`LSBC_F_FULL];
        fset[`LSBC_F_WCL]   = wr_data & ~flags_q[`LSBC_F_VAC];
        fset[`LSBC_F_FORCE] = t_force;
        fset[`LSBC_F_IDLE]  = idle_hit;
        fclr = rd_flags ? (flags_q & `LSBC_RC_MASK) : '0;
        fclr[`LSBC_F_FULL] = rd_data;
        fclr[`LSBC_F_VAC]  = wr_data & flags_q[`LSBC_F_VAC];
        flags_d = (flags_q & ~fclr) | fset;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            flags_q <= `LSBC_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ==========================================================
    // Assertions
    AST_ABORT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        abort |=> !rx_synced_q && !rx_busy_q && rx_st_q == lsbc_pkg::RX_HUNT)
        else $error("abort left receiver active");
    AST_PATH_OFF: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ctrl_q.path_off [*2] |-> rxf_q && rx_st_q == lsbc_pkg::RX_HUNT)
        else $error("receive path active while off");
    AST_IDLE_OFF: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !ctrl_q.idle_on |=> idle_q == 32'h0 && !idle_hit)
        else $error("idle timer ran while disabled");
    AST_SYNC_SET: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        det && !tx_start |=> rx_synced_q && flags_q[`LSBC_F_HDR])
        else $error("header detection not reported");
    AST_STOP_CLR: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        byte_done |=> !rx_busy_q)
        else $error("frame busy kept after stop bit");
    AST_TX_END: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        t_clash || t_force |=> !tx_busy && LIN_TXD)
        else $error("transmitter kept driving after fault");
    AST_DIV_LOAD: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        det |=> div == $past(bitlen[14:0]) - 15'h1)
        else $error("divisor not loaded from measurement");
    AST_OVERRUN: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        byte_done && flags_q[`LSBC_F_FULL] |=> flags_q[`LSBC_F_OVR] && $stable(rxbuf_q))
        else $error("overrun not handled");
    AST_WCLASH: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        wr_data && !flags_q[`LSBC_F_VAC] |=> flags_q[`LSBC_F_WCL] && $stable(txbuf_q))
        else $error("write into full buffer not rejected");
    AST_RD_CLR: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        rd_flags && !fset[`LSBC_F_CLASH] |=> !flags_q[`LSBC_F_CLASH])
        else $error("status read did not clear flag");
    COV_SYNC: cover property (@(posedge SYS_CLK) disable iff (!RST_N) det);
    COV_BYTE: cover property (@(posedge SYS_CLK) disable iff (!RST_N) byte_done);
    COV_TXEND: cover property (@(posedge SYS_CLK) disable iff (!RST_N) t_end && !t_reload);
    COV_CLASH: cover property (@(posedge SYS_CLK) disable iff (!RST_N) t_clash);
endmodule : lsbc_top

// ---- logic/lsbc_cfg.svh ----
`ifndef LSBC_CFG_SVH
`define LSBC_CFG_SVH
`define LSBC_A_CTRL     32'h4000_1800
`define LSBC_A_FLAGS    32'h4000_1804
`define LSBC_A_DATA     32'h4000_1808
`define LSBC_A_MASK     32'h4000_180c
`define LSBC_A_DIVLO    32'h4000_1810
`define LSBC_A_DIVHI    32'h4000_1814
`define LSBC_C_ABORT    0
`define LSBC_C_OFF      1
`define LSBC_C_FAST     2
`define LSBC_C_IDLE     3
`define LSBC_F_HDR      0
`define LSBC_F_FULL     1
`define LSBC_F_VAC      2
`define LSBC_F_CLASH    3
`define LSBC_F_OVR      4
`define LSBC_F_WCL      5
`define LSBC_F_FORCE    6
`define LSBC_F_IDLE     7
`define LSBC_FLAGS_RST  8'h04
`define LSBC_RC_MASK    8'hf9
`define LSBC_DIVLO_RST  8'he7
`define LSBC_DIVHI_RST  7'h03
`define LSBC_CLK_HZ     125000000
`define LSBC_TICK0_HZ   (`LSBC_CLK_HZ / 2)
`define LSBC_RATE_MIN   1000
`define LSBC_RATE_SLOW  30000
`define LSBC_RATE_FAST  200000
`define LSBC_RATE_F3    100000
`define LSBC_BIT_MAX0   (`LSBC_TICK0_HZ / `LSBC_RATE_MIN)
`define LSBC_CEIL(a, b) (((a) + (b) - 1) / (b))
`define LSBC_BIT_SLOW0  `LSBC_CEIL(`LSBC_TICK0_HZ, `LSBC_RATE_SLOW)
`define LSBC_BIT_FAST0  `LSBC_CEIL(`LSBC_TICK0_HZ, `LSBC_RATE_FAST)
`define LSBC_BIT_F30    `LSBC_CEIL(`LSBC_TICK0_HZ, `LSBC_RATE_F3)
`define LSBC_BIT_TOP    32768
`define LSBC_IDLE_S     4
`define LSBC_IDLE_CYC   (`LSBC_IDLE_S * `LSBC_CLK_HZ + 1)
`define LSBC_FILT       2'd2
`define LSBC_BRK_BITS   11
`define LSBC_SYNC_SH    3
`define LSBC_SYNC_LAST  3'd4
`define LSBC_LAST_BIT   4'd9
`define LSBC_PRESC_F3   2'd3
`endif

// ---- logic/lsbc_pkg.sv ----
package lsbc_pkg;
    typedef enum logic [2:0] {
        RX_HUNT  = 3'b000,
        RX_BREAK = 3'b001,
        RX_SYNC  = 3'b010,
        RX_IDLE  = 3'b011,
        RX_DATA  = 3'b100
    } lsbc_rx_e;
    typedef enum logic {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } lsbc_tx_e;
    typedef struct packed {
        logic idle_on;
        logic fast;
        logic path_off;
    } lsbc_ctrl_s;
    typedef logic [7:0] lsbc_flags_t;
endpackage : lsbc_pkg

// ---- verif/lsbc_lin_master.sv ----
`timescale 1ns/100ps
// The bus wire is wired-AND: a 0 from either party dominates.
module lsbc_lin_master #(
    parameter int BIT = 640
) (
    input  wire logic clk,
    input  wire logic txd,
    input  wire logic stuck_hi,
    output logic      rxd
);
    logic drv = 1'b1;
    // Stuck high models a protection circuit that cut the node's driver.
    assign rxd = stuck_hi | (drv & txd);
    task send_bit(input logic b);
        drv <= b;
        repeat (BIT) @(posedge clk);
    endtask : send_bit
    task send_byte(input logic [7:0] d);
        send_bit(1'b0);
        for (int i = 0; i < 8; i++)
            send_bit(d[i]);
        send_bit(1'b1);
    endtask : send_byte
    task send_header();
        repeat (13) send_bit(1'b0);
        send_bit(1'b1);
        send_byte(8'h55);
    endtask : send_header
endmodule : lsbc_lin_master

// ---- verif/lsbc_top_bench.sv ----
`timescale 1ns/100ps
`include "lsbc_cfg.svh"
module lsbc_top_bench;
    localparam int BIT = 640;
    localparam logic [31:0] CT = `LSBC_A_CTRL;
    localparam logic [31:0] FL = `LSBC_A_FLAGS;
    localparam logic [31:0] DT = `LSBC_A_DATA;
    localparam logic [31:0] MK = `LSBC_A_MASK;
    logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, stuck_hi = 0;
    logic [31:0] adr = '0, wdat = '0, rdat, q;
    logic        ack, txd, irq, rxd;
    int          num_errors = 0, n_compared = 0, cycles = 0;
    always #4 clk = ~clk;
    lsbc_top #(.IDLE_CYC(200)) u_dut (
        .SYS_CLK(clk), .RST_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_SEL_I(4'hf), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .LIN_PRESCALE(2'h0),
        .LIN_RXD(rxd), .LIN_TXD(txd), .LIN_IRQ(irq));
    lsbc_lin_master #(.BIT(BIT)) u_master (
        .clk(clk), .txd(txd), .stuck_hi(stuck_hi), .rxd(rxd));
    // ==========================================
    // Shared tasks.
    task end_sim();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task rd(input logic [31:0] a, input logic [31:0] exp);
        wb(1'b0, a, '0);
        chk(q, exp);
    endtask : rd
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            num_errors++;
            end_sim();
        end
    end
    // ==========================================
    // Scenarios.
    task t_reset();
        rd(FL, 32'h04);
        rd(`LSBC_A_DIVLO, 32'he7);
        rd(`LSBC_A_DIVHI, 32'h03);
        rd(32'h4000_1818, 32'h0);
        wb(1'b1, MK, 32'hffff_ff5a);
        rd(MK, 32'h5a);
    endtask : t_reset
    task t_header();
        wb(1'b1, CT, 32'h4);
        u_master.send_header();
        rd(CT, 32'h14);
        rd(FL, 32'h05);
        rd(FL, 32'h04);
        rd(`LSBC_A_DIVLO, 32'h3f);
        rd(`LSBC_A_DIVHI, 32'h01);
    endtask : t_header
    task t_rx();
        u_master.send_byte(8'ha5);
        u_master.send_byte(8'h3c);
        rd(FL, 32'h16);
        rd(DT, 32'ha5);
        rd(FL, 32'h04);
    endtask : t_rx
    task t_abort_off();
        wb(1'b1, CT, 32'h5);
        rd(CT, 32'h04);
        wb(1'b1, CT, 32'h6);
        u_master.send_header();
        rd(CT, 32'h06);
        rd(FL, 32'h04);
        wb(1'b1, CT, 32'h4);
    endtask : t_abort_off
    task t_tx();
        wb(1'b1, DT, 32'h96);
        wb(1'b1, DT, 32'h11);
        wb(1'b1, DT, 32'h22);
        rd(FL, 32'h20);
        rd(CT, 32'h44);
        repeat (2 * BIT) @(posedge clk);
        chk({31'h0, txd}, 32'h1);
        repeat (19 * BIT) @(posedge clk);
        rd(CT, 32'h04);
        rd(FL, 32'h04);
    endtask : t_tx
    task t_forced();
        stuck_hi <= 1'b1;
        wb(1'b1, DT, 32'h00);
        repeat (2 * BIT) @(posedge clk);
        rd(FL, 32'h44);
        rd(CT, 32'h04);
        stuck_hi <= 1'b0;
    endtask : t_forced
    task t_clash();
        wb(1'b1, DT, 32'hff);
        repeat (BIT) @(posedge clk);
        u_master.send_bit(1'b0);
        u_master.send_bit(1'b1);
        rd(FL, 32'h0c);
        rd(CT, 32'h04);
        rd(FL, 32'h04);
    endtask : t_clash
    task t_div_prog();
        wb(1'b1, `LSBC_A_DIVHI, 32'h0);
        wb(1'b1, `LSBC_A_DIVLO, 32'h3);
        rd(`LSBC_A_DIVLO, 32'h03);
        rd(`LSBC_A_DIVHI, 32'h00);
    endtask : t_div_prog
    task t_irq_idle();
        wb(1'b1, MK, 32'h04);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, MK, 32'hfb);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, CT, 32'h0c);
        repeat (300) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rd(FL, 32'h84);
    endtask : t_irq_idle
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_header();
        t_rx();
        t_abort_off();
        t_tx();
        t_forced();
        t_clash();
        t_irq_idle();
        t_div_prog();
        end_sim();
    end
endmodule : lsbc_top_bench
